/* File: common/bridge_pins_pkg.sv */
// Constants and carrier types for the bridge control pin logic
package bridge_pins_pkg;

  // Core clock: crystal reference
  localparam int unsigned CLK_HZ = 30_000_000;
  localparam int unsigned CLK_PERIOD_PS = 1_000_000_000 / (CLK_HZ / 1000);

  // Pin counts and filter counter width
  localparam int unsigned GPIO_W = 10;
  localparam int unsigned TEST_SEL_W = 4;
  localparam int unsigned FILT_CNT_W = 8;
  localparam int unsigned FILT_CH = 2;

  // Filter channel indexes
  localparam int unsigned CH_MEDIA = 0;
  localparam int unsigned CH_EJECT = 1;

  // Default stable-sample count for media and eject filters
  localparam logic [FILT_CNT_W-1:0] FILT_LEN_DEF = 8'h08;

  // Configuration value that grants full bus power
  localparam logic [7:0] CFG_VALUE_ACTIVE = 8'h01;

  // Fabrication test inputs in normal operation
  localparam logic [TEST_SEL_W-1:0] TEST_SEL_IDLE = 4'h0;

  // Values after reset
  localparam logic [GPIO_W-1:0] GPIO_RST = 10'h000;
  localparam logic [FILT_CH-1:0] FILT_LEVEL_RST = 2'h3;

  // Asynchronous control inputs, sampled as one group
  typedef struct packed {
    logic port_enable;
    logic int_gate;
    logic drive_ready;
    logic current_class;
    logic bus_power;
    logic drive_power;
  } ctl_raw_s;

  // Status presented to the USB core
  typedef struct packed {
    logic drive_ready;
    logic drive_power_ok;
    logic current_500ma;
    logic bus_power_present;
    logic test_straps_bad;
  } ctl_status_s;

endpackage

/* File: design/bridge_control_pins.sv */
// Control and status pin logic of the USB to ATA bridge
`timescale 1ns/100ps
`default_nettype none

module bridge_control_pins
  import bridge_pins_pkg::*;
#(
  parameter int unsigned GPIO_WIDTH = GPIO_W
) (
  input wire logic clk,
  input wire logic chip_reset_n,
  input wire ctl_raw_s ctl_raw,
  input wire logic [TEST_SEL_W-1:0] fab_test_sel,
  input wire logic scan_enable,
  input wire logic media_present_n,
  input wire logic eject_request_n,
  input wire logic [GPIO_WIDTH-1:0] gen_io_pins_in,
  input wire logic [GPIO_WIDTH-1:0] cfg_gpio_oe,
  input wire logic [GPIO_WIDTH-1:0] cfg_gpio_out,
  input wire logic cfg_drive_pwr_used,
  input wire logic cfg_drive_pwr_high,
  input wire logic [FILT_CNT_W-1:0] cfg_filter_len,
  input wire logic [7:0] usb_config_value,
  input wire logic usb_low_power,
  input wire logic usb_suspend,
  input wire logic usb_wakeup_enabled,
  input wire logic int_pipe_req,
  input wire logic [7:0] int_pipe_data,
  output logic ata_outputs_oe_q,
  output logic ata_sm_run_q,
  output logic int_pipe_valid_q,
  output logic int_pipe_nak_q,
  output logic [7:0] int_pipe_data_q,
  output ctl_status_s status_q,
  output logic low_power_ind_n_out_q,
  output logic low_power_ind_n_oe_q,
  output logic bus_power_granted_n_out_q,
  output logic bus_power_granted_n_oe_q,
  output logic ready_pullup_enable_out_q,
  output logic ready_pullup_enable_oe_q,
  output logic [GPIO_WIDTH-1:0] gen_io_pins_out_q,
  output logic [GPIO_WIDTH-1:0] gen_io_pins_oe_q,
  output logic [GPIO_WIDTH-1:0] gen_io_pins_sync_q,
  output logic [FILT_CH-1:0] media_eject_level_q,
  output logic remote_wakeup_q
);

  localparam int unsigned RAW_W = $bits(ctl_raw_s) + FILT_CH + GPIO_WIDTH
    + TEST_SEL_W + 1;

  // Sync stages reset to the idle level of the active-low media and
  // eject pins, so the filters see no false edge on reset release
  localparam logic [RAW_W-1:0] SYNC_RST = RAW_W'(FILT_LEVEL_RST)
    << (GPIO_WIDTH + TEST_SEL_W + 1);

  // two-stage synchroniser
  // Stage one feeds stage two only; everything reads stage two
  logic [RAW_W-1:0] meta_q, sync_q;
  // Assertion guard: high from the first edge that runs out of reset
  logic live_q;
  ctl_raw_s ctl_s;
  logic [FILT_CH-1:0] filt_raw_s;
  logic [GPIO_WIDTH-1:0] gpio_s;
  logic [TEST_SEL_W-1:0] test_s;
  logic scan_s;

  always_ff @(posedge clk or negedge chip_reset_n) begin
    if (!chip_reset_n) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      meta_q <= {ctl_raw, eject_request_n, media_present_n, gen_io_pins_in,
                 fab_test_sel, scan_enable};
      sync_q <= meta_q;
    end
  end

  // Unpack the settled samples
  always_comb begin
    {ctl_s, filt_raw_s, gpio_s, test_s, scan_s} = sync_q;
  end

  logic [FILT_CH-1:0] filt_level, filt_change;
  genvar g;
  generate
    for (g = 0; g < FILT_CH; g++) begin : g_filt
      glitch_filter #(
        .CNT_W(FILT_CNT_W),
        .RST_LEVEL(FILT_LEVEL_RST[g])
      ) u_filt (
        .clk(clk),
        .chip_reset_n(chip_reset_n),
        .level_in(filt_raw_s[g]),
        .stable_len(cfg_filter_len),
        .level_q(filt_level[g]),
        .change_q(filt_change[g])
      );
    end
  endgenerate

  // Next values of the output registers, except the open-drain outputs, the GPIO readback and the filter levels
  logic ata_oe_d, ata_run_d, ip_valid_d, ip_nak_d, wake_d;
  logic lp_oe_d, grant_oe_d, pu_out_d, pu_oe_d;
  logic [7:0] ip_data_d;
  logic [GPIO_WIDTH-1:0] gpio_out_d, gpio_oe_d;
  ctl_status_s status_d;

  always_comb begin
    // port enabled runs ATA; disabled floats and halts it
    ata_oe_d = ctl_s.port_enable;
    ata_run_d = ctl_s.port_enable;
    // interrupt data gated by the gate input
    ip_valid_d = int_pipe_req && ctl_s.int_gate;
    ip_nak_d = int_pipe_req && !ctl_s.int_gate;
    ip_data_d = ip_valid_d ? int_pipe_data : int_pipe_data_q;
    status_d.drive_ready = ctl_s.drive_ready;
    status_d.drive_power_ok = cfg_drive_pwr_used &&
      (ctl_s.drive_power == cfg_drive_pwr_high);
    // current class, high means 500 mA class
    status_d.current_500ma = ctl_s.current_class;
    status_d.bus_power_present = ctl_s.bus_power;
    // Flag misuse of test straps, which must stay idle
    status_d.test_straps_bad = (test_s != TEST_SEL_IDLE) || scan_s;
    // low-power indicator; open drain pulls low only
    lp_oe_d = usb_low_power;
    grant_oe_d = (usb_config_value == CFG_VALUE_ACTIVE);
    // pull-up low in suspend, floats with port disabled
    pu_out_d = !usb_suspend;
    pu_oe_d = ctl_s.port_enable;
    gpio_oe_d = cfg_gpio_oe;
    gpio_out_d = cfg_gpio_out;
    // wakeup on any filtered edge when enabled
    wake_d = usb_wakeup_enabled && (|filt_change);
  end

  // reset releases indicators and floats the GPIOs
  always_ff @(posedge clk or negedge chip_reset_n) begin
    if (!chip_reset_n) begin
      ata_outputs_oe_q <= 1'b0;
      ata_sm_run_q <= 1'b0;
      int_pipe_valid_q <= 1'b0;
      int_pipe_nak_q <= 1'b0;
      int_pipe_data_q <= 8'h00;
      status_q <= '0;
      low_power_ind_n_out_q <= 1'b0;
      low_power_ind_n_oe_q <= 1'b0;
      bus_power_granted_n_out_q <= 1'b0;
      bus_power_granted_n_oe_q <= 1'b0;
      ready_pullup_enable_out_q <= 1'b0;
      ready_pullup_enable_oe_q <= 1'b0;
      gen_io_pins_out_q <= GPIO_RST;
      gen_io_pins_oe_q <= GPIO_RST;
      gen_io_pins_sync_q <= GPIO_RST;
      media_eject_level_q <= FILT_LEVEL_RST;
      remote_wakeup_q <= 1'b0;
    end else begin
      ata_outputs_oe_q <= ata_oe_d;
      ata_sm_run_q <= ata_run_d;
      int_pipe_valid_q <= ip_valid_d;
      int_pipe_nak_q <= ip_nak_d;
      int_pipe_data_q <= ip_data_d;
      status_q <= status_d;
      low_power_ind_n_out_q <= 1'b0; // Open drain: only ever drives low
      low_power_ind_n_oe_q <= lp_oe_d;
      bus_power_granted_n_out_q <= 1'b0;
      bus_power_granted_n_oe_q <= grant_oe_d;
      ready_pullup_enable_out_q <= pu_out_d;
      ready_pullup_enable_oe_q <= pu_oe_d;
      gen_io_pins_out_q <= gpio_out_d;
      gen_io_pins_oe_q <= gpio_oe_d;
      gen_io_pins_sync_q <= gpio_s;
      media_eject_level_q <= filt_level;
      remote_wakeup_q <= wake_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  // Release lands at a clock edge that still sees reset; skip that edge
  default disable iff (!chip_reset_n || !live_q);

  property p_ata_off;
    !ctl_raw.port_enable ##2 !ctl_s.port_enable |=>
      !ata_outputs_oe_q && !ata_sm_run_q;
  endproperty
  a_ata_off: assert property (p_ata_off)
    else $error("ATA outputs driven while port disabled");

  property p_ata_on;
    ctl_raw.port_enable [*4] |-> ata_outputs_oe_q && ata_sm_run_q;
  endproperty
  a_ata_on: assert property (p_ata_on)
    else $error("ATA port not running while enabled");

  property p_int_gate;
    int_pipe_valid_q |-> $past(int_pipe_req) && $past(ctl_s.int_gate)
      && int_pipe_data_q == $past(int_pipe_data);
  endproperty
  a_int_gate: assert property (p_int_gate)
    else $error("interrupt data returned while gated off");

  property p_int_nak;
    int_pipe_req && !ctl_s.int_gate |=> int_pipe_nak_q && !int_pipe_valid_q;
  endproperty
  a_int_nak: assert property (p_int_nak)
    else $error("gated interrupt request not refused");

  property p_low_power;
    usb_low_power |=> low_power_ind_n_oe_q && !low_power_ind_n_out_q;
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low-power indicator not asserted");

  property p_granted;
    usb_config_value == CFG_VALUE_ACTIVE |=> bus_power_granted_n_oe_q;
  endproperty
  a_granted: assert property (p_granted)
    else $error("bus power grant missing after configuration");

  property p_open_drain;
    !low_power_ind_n_out_q && !bus_power_granted_n_out_q;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain indicator driven high");

  property p_gpio_oe;
    ##1 gen_io_pins_oe_q == $past(cfg_gpio_oe);
  endproperty
  a_gpio_oe: assert property (p_gpio_oe)
    else $error("GPIO enable differs from configuration");

  property p_wakeup;
    remote_wakeup_q |-> $past(usb_wakeup_enabled) && $past(|filt_change);
  endproperty
  a_wakeup: assert property (p_wakeup)
    else $error("wakeup without enabled filtered change");

  property p_pullup;
    $fell(ctl_s.port_enable) |=> !ready_pullup_enable_oe_q;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up enable driven while port disabled");

  c_int_data: cover property (int_pipe_valid_q);
  c_wake_media: cover property (filt_change[CH_MEDIA] && usb_wakeup_enabled
    ##1 remote_wakeup_q);
  c_wake_eject: cover property (filt_change[CH_EJECT] ##1 remote_wakeup_q);
  c_port_off: cover property ($fell(ata_outputs_oe_q));

endmodule // bridge_control_pins

`default_nettype wire

/* File: design/glitch_filter.sv */
// Stable-sample filter for one synchronised level input
`timescale 1ns/100ps
`default_nettype none

module glitch_filter
  import bridge_pins_pkg::*;
#(
  parameter int unsigned CNT_W = FILT_CNT_W,
  parameter logic RST_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic chip_reset_n,
  input wire logic level_in,
  input wire logic [CNT_W-1:0] stable_len,
  output logic level_q,
  output logic change_q
);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic level_d, change_d;

  // Count samples that disagree with the accepted level
  always_comb begin
    level_d = level_q;
    change_d = 1'b0;
    cnt_d = '0;
    if (level_in != level_q) begin
      if (cnt_q + CNT_W'(1) >= stable_len) begin
        level_d = level_in;
        change_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  // Async reset, constants only
  always_ff @(posedge clk or negedge chip_reset_n) begin
    if (!chip_reset_n) begin
      cnt_q <= '0;
      level_q <= RST_LEVEL;
      change_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      level_q <= level_d;
      change_q <= change_d;
    end
  end

  property p_filt_stable;
    @(posedge clk) disable iff (!chip_reset_n)
    change_q |-> $past(level_in) != $past(level_q);
  endproperty
  a_filt_stable: assert property (p_filt_stable)
    else $error("filter changed without a differing sample");

  property p_filt_no_glitch;
    @(posedge clk) disable iff (!chip_reset_n)
    (stable_len > CNT_W'(1)) && (level_in != level_q) && (cnt_q == '0)
      |=> !change_q;
  endproperty
  a_filt_no_glitch: assert property (p_filt_no_glitch)
    else $error("single differing sample passed the filter");

endmodule // glitch_filter

`default_nettype wire

/* File: dv/board_drive_model.sv */
// Board and drive model facing the bridge control pins
`timescale 1ns/100ps
`default_nettype none

module board_drive_model
  import bridge_pins_pkg::*;
(
  input wire logic clk,
  input wire ctl_raw_s cmd_raw,
  input wire logic [7:0] ready_dly,
  input wire logic [GPIO_W-1:0] ext_oe,
  input wire logic [GPIO_W-1:0] ext_val,
  input wire logic [GPIO_W-1:0] dev_oe,
  input wire logic [GPIO_W-1:0] dev_out,
  output ctl_raw_s ctl_raw,
  output logic [TEST_SEL_W-1:0] fab_test_sel,
  output logic scan_enable,
  output logic [GPIO_W-1:0] pad
);
  logic [7:0] pwr_cnt_q = 8'h00;

  // Drive needs ready_dly cycles after power before it takes commands
  always_ff @(posedge clk) begin
    if (!cmd_raw.drive_power)
      pwr_cnt_q <= 8'h00;
    else if (pwr_cnt_q != 8'hFF)
      pwr_cnt_q <= pwr_cnt_q + 8'h01;
  end

  // Ready follows power, never before the delay
  always_comb begin
    ctl_raw = cmd_raw;
    ctl_raw.drive_ready = cmd_raw.drive_power && (pwr_cnt_q >= ready_dly);
  end

  assign fab_test_sel = TEST_SEL_IDLE;
  assign scan_enable = 1'b0;
  // Pads: device drive wins, else board drive, else pull-down
  assign pad = (dev_oe & dev_out) | (~dev_oe & ext_oe & ext_val);
endmodule // board_drive_model

`default_nettype wire

/* File: dv/tb_bridge_control_pins.sv */
// Self-checking testbench for the bridge control pins
`timescale 1ns/100ps
`default_nettype none

module tb_bridge_control_pins
  import bridge_pins_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, media_n = 1'b1, eject_n = 1'b1;
  ctl_raw_s cmd_raw = '0, ctl_raw;
  logic [7:0] ready_dly = 8'h00, cfg_val = 8'h00, req_data = 8'h00;
  logic [7:0] flen = 8'h02, ip_data;
  logic [GPIO_W-1:0] ext_oe = '0, ext_val = '0, cfg_oe = '0, cfg_out = '0;
  logic [GPIO_W-1:0] pad, gp_out, gp_oe, gp_sync;
  logic pwr_used = 1'b0, pwr_high = 1'b0, lowp = 1'b0, susp = 1'b0;
  logic wk_en = 1'b0, req = 1'b0;
  logic ata_oe, ata_run, ip_valid, ip_nak, lp_out, lp_oe, gr_out, gr_oe;
  logic pu_out, pu_oe, wake, scan;
  logic [TEST_SEL_W-1:0] tsel;
  logic [FILT_CH-1:0] lvl;
  ctl_status_s st;
  int failures = 0, cmp_count = 0, wake_cnt = 0;

  bridge_control_pins i_bridge_control_pins (
    .clk(clk), .chip_reset_n(rst_n), .ctl_raw(ctl_raw),
    .fab_test_sel(tsel), .scan_enable(scan), .media_present_n(media_n),
    .eject_request_n(eject_n), .gen_io_pins_in(pad), .cfg_gpio_oe(cfg_oe),
    .cfg_gpio_out(cfg_out), .cfg_drive_pwr_used(pwr_used),
    .cfg_drive_pwr_high(pwr_high), .cfg_filter_len(flen),
    .usb_config_value(cfg_val), .usb_low_power(lowp), .usb_suspend(susp),
    .usb_wakeup_enabled(wk_en), .int_pipe_req(req), .int_pipe_data(req_data),
    .ata_outputs_oe_q(ata_oe), .ata_sm_run_q(ata_run),
    .int_pipe_valid_q(ip_valid), .int_pipe_nak_q(ip_nak),
    .int_pipe_data_q(ip_data), .status_q(st), .low_power_ind_n_out_q(lp_out),
    .low_power_ind_n_oe_q(lp_oe), .bus_power_granted_n_out_q(gr_out),
    .bus_power_granted_n_oe_q(gr_oe), .ready_pullup_enable_out_q(pu_out),
    .ready_pullup_enable_oe_q(pu_oe), .gen_io_pins_out_q(gp_out),
    .gen_io_pins_oe_q(gp_oe), .gen_io_pins_sync_q(gp_sync),
    .media_eject_level_q(lvl), .remote_wakeup_q(wake));

  board_drive_model i_board_drive_model (
    .clk(clk), .cmd_raw(cmd_raw), .ready_dly(ready_dly), .ext_oe(ext_oe),
    .ext_val(ext_val), .dev_oe(gp_oe), .dev_out(gp_out), .ctl_raw(ctl_raw),
    .fab_test_sel(tsel), .scan_enable(scan), .pad(pad));

  // Clock, 25 ns period
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Wakeup pulses seen at the port
  always @(posedge clk) begin
    if (wake === 1'b1)
      wake_cnt++;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Sample just after the edge so registered outputs have landed
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic t_port();
    @(posedge clk);
    cmd_raw.port_enable <= 1'b1;
    wt(2);
    chk("ata_oe early", 0, ata_oe);
    wt(1);
    chk("ata_oe", 1, ata_oe);
    chk("ata_run", 1, ata_run);
    chk("pullup oe", 1, pu_oe);
    @(posedge clk);
    susp <= 1'b1;
    wt(1);
    chk("pullup out", 0, pu_out);
    @(posedge clk);
    cmd_raw.port_enable <= 1'b0;
    susp <= 1'b0;
    wt(3);
    chk("ata_oe off", 0, ata_oe);
    chk("ata_run off", 0, ata_run);
    chk("pullup oe off", 0, pu_oe);
    $display("test port done");
  endtask

  task automatic send(input logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    req_data <= d;
    @(posedge clk);
    req <= 1'b0;
    // Valid and refusal stand one cycle: look just after they rise
    #1;
  endtask

  task automatic t_ipipe();
    @(posedge clk);
    cmd_raw.int_gate <= 1'b1;
    wt(3);
    send(8'hA5);
    chk("ip valid", 2'b10, {ip_valid, ip_nak});
    chk("ip data", 8'hA5, ip_data);
    @(posedge clk);
    cmd_raw.int_gate <= 1'b0;
    wt(3);
    send(8'h3C);
    chk("ip refused", 2'b01, {ip_valid, ip_nak});
    chk("ip data held", 8'hA5, ip_data);
    $display("test interrupt pipe done");
  endtask

  task automatic t_status();
    @(posedge clk);
    ready_dly <= 8'h04;
    cmd_raw.drive_power <= 1'b1;
    cmd_raw.current_class <= 1'b1;
    cmd_raw.bus_power <= 1'b1;
    pwr_used <= 1'b1;
    pwr_high <= 1'b1;
    wt(3);
    chk("status slow drive", 5'b01110, st);
    wt(5);
    chk("status ready", 5'b11110, st);
    @(posedge clk);
    pwr_high <= 1'b0;
    wt(1);
    chk("status low polarity", 5'b10110, st);
    @(posedge clk);
    pwr_high <= 1'b1;
    pwr_used <= 1'b0;
    wt(1);
    chk("status unused", 5'b10110, st);
    @(posedge clk);
    cmd_raw.bus_power <= 1'b0;
    cmd_raw.current_class <= 1'b0;
    wt(3);
    chk("status no bus", 5'b10000, st);
    $display("test status done");
  endtask

  task automatic t_ind();
    @(posedge clk);
    cfg_val <= 8'h02;
    wt(1);
    chk("grant oe cfg2", 0, gr_oe);
    @(posedge clk);
    cfg_val <= CFG_VALUE_ACTIVE;
    lowp <= 1'b1;
    wt(1);
    chk("grant pin", 2'b10, {gr_oe, gr_out});
    chk("low power pin", 2'b10, {lp_oe, lp_out});
    $display("test indicators done");
  endtask

  task automatic t_gpio();
    @(posedge clk);
    cfg_oe <= 10'h2A5;
    cfg_out <= 10'h0F0;
    ext_oe <= 10'h15A;
    ext_val <= 10'h3C3;
    wt(1);
    chk("gpio oe", 10'h2A5, gp_oe);
    chk("gpio out", 10'h0F0, gp_out);
    wt(3);
    chk("gpio readback", 10'h1E2, gp_sync);
    $display("test gpio done");
  endtask

  task automatic t_filt();
    int n0;
    @(posedge clk);
    wk_en <= 1'b1;
    wt(2);
    n0 = wake_cnt;
    @(posedge clk);
    media_n <= 1'b0;
    @(posedge clk);
    media_n <= 1'b1;
    wt(8);
    chk("glitch level", 2'b11, lvl);
    chk("glitch wakeups", n0, wake_cnt);
    @(posedge clk);
    media_n <= 1'b0;
    wt(4);
    chk("level early", 2'b11, lvl);
    wt(1);
    chk("media level", 2'b10, lvl);
    chk("wakeup pulse", 1, wake);
    wt(1);
    chk("wakeup end", 0, wake);
    @(posedge clk);
    wk_en <= 1'b0;
    eject_n <= 1'b0;
    wt(8);
    chk("eject level", 2'b00, lvl);
    chk("wakeups masked", n0 + 1, wake_cnt);
    @(posedge clk);
    wk_en <= 1'b1;
    eject_n <= 1'b1;
    wt(5);
    chk("eject release level", 2'b10, lvl);
    chk("eject wakeup", 1, wake);
    wt(1);
    chk("eject wakeups", n0 + 2, wake_cnt);
    $display("test filters done");
  endtask

  task automatic t_areset();
    @(posedge clk);
    cmd_raw.port_enable <= 1'b1;
    wt(3);
    #5;
    rst_n = 1'b0;
    #1;
    chk("reset oes", 0, {gp_oe, lp_oe, gr_oe, ata_oe, pu_oe});
    chk("reset level", 2'b11, lvl);
    @(posedge clk);
    rst_n <= 1'b1;
    wt(3);
    chk("after reset", {10'h2A5, 1'b1}, {gp_oe, ata_oe});
    $display("test async reset done");
  endtask

  // Main sequence
  initial begin
    // reset hold, shortened to ten cycles
    repeat (10) @(posedge clk);
    #1;
    chk("in reset", 3, {gp_oe, lp_oe, gr_oe, ata_oe, pu_oe, lvl});
    @(posedge clk);
    rst_n <= 1'b1;
    wt(3);
    t_port();
    t_ipipe();
    t_status();
    t_ind();
    t_gpio();
    t_filt();
    t_areset();
    finish_test();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule // tb_bridge_control_pins

`default_nettype wire
